/* rtl/rsl_pkg.sv */
// constants, register map and state type for reference select and lock indication
package rsl_pkg;

    // clock and timing
    localparam int CLK_HZ          = 25_000_000;
    localparam int CYC_PER_MS      = CLK_HZ / 1000;
    localparam int HOLD_SLOT_MS    = 26;
    localparam int HOLD_SLOT_CYC   = CYC_PER_MS * HOLD_SLOT_MS;
    localparam int LOCK_TIME_MS    = 1000;
    localparam int LOCK_CYC        = CYC_PER_MS * LOCK_TIME_MS;
    localparam int SLOPE_US_PER_S  = 61;
    localparam int SLOPE_TICK_MS   = 1;
    localparam int SLOPE_TICK_CYC  = CYC_PER_MS * SLOPE_TICK_MS;
    // phase lsb is 1 ns, so the step per tick is ns per ms of slope
    localparam int SLOPE_STEP_NS   = SLOPE_US_PER_S * SLOPE_TICK_MS;

    // widths
    localparam int PHASE_W         = 16;
    localparam int FREQ_W          = 32;
    localparam int ADDR_W          = 8;
    localparam int IRQ_W           = 4;

    // operating state select encodings
    localparam logic [1:0] MODE_AUTO     = 2'h0;
    localparam logic [1:0] MODE_HOLD     = 2'h1;
    localparam logic [1:0] MODE_FREE     = 2'h2;

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_LOCK_WIN  = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_HOLD_FREQ = 8'h10;

    // status register fields
    localparam int ST_LOCK_BIT     = 0;
    localparam int ST_REF_BIT      = 1;
    localparam int ST_STATE_LSB    = 4;

    // interrupt bit positions
    localparam int IRQ_LOCK_GAIN   = 0;
    localparam int IRQ_LOCK_LOSS   = 1;
    localparam int IRQ_REF_SWITCH  = 2;
    localparam int IRQ_HOLD_ENTRY  = 3;

    // reset values
    localparam logic [PHASE_W-1:0] LOCK_WIN_RST = 16'h0064;
    localparam logic [IRQ_W-1:0]   IRQ_MASK_RST = 4'h0;
    localparam logic [FREQ_W-1:0]  FREQ_NOMINAL = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_TIE,
        ST_NORMAL,
        ST_FREE
    } rsl_state_t;

endpackage : rsl_pkg

/* rtl/rsl_slope_limiter.sv */
// output phase slope limiter: phase follows its target by a bounded step per tick
`timescale 1ns/100ps
module rsl_slope_limiter #(
    parameter int PW       = rsl_pkg::PHASE_W,
    parameter int STEP     = rsl_pkg::SLOPE_STEP_NS,
    parameter int TICK_CYC = rsl_pkg::SLOPE_TICK_CYC
) (
    // clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    // control and data
    input  wire logic                 en_i,
    input  wire logic signed [PW-1:0] target_i,
    output logic signed [PW-1:0]      phase_o
);
    localparam int TW = $clog2(TICK_CYC + 1);
    localparam logic signed [PW:0] STEP_S = (PW+1)'(STEP);

    logic [TW-1:0]        tick_q, tick_d;
    logic signed [PW-1:0] phase_q, phase_d;
    logic signed [PW:0]   diff;

    always_comb begin
        diff    = {target_i[PW-1], target_i} - {phase_q[PW-1], phase_q};
        tick_d  = tick_q + TW'(1);
        phase_d = phase_q;
        if (tick_q == TW'(TICK_CYC - 1)) begin
            tick_d = '0;
            if (en_i) begin
                if (diff > STEP_S) begin
                    phase_d = phase_q + PW'(STEP);
                end else if (diff < -STEP_S) begin
                    phase_d = phase_q - PW'(STEP);
                end else begin
                    phase_d = target_i;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tick_q  <= '0;
            phase_q <= '0;
        end else begin
            tick_q  <= tick_d;
            phase_q <= phase_d;
        end
    end

    assign phase_o = phase_q;

    property p_slope_bound;
        @(posedge ref_clk_i) disable iff (rst_i)
        ##1 ((phase_q - $past(phase_q) <= PW'(STEP)) &&
             ($past(phase_q) - phase_q <= PW'(STEP)));
    endproperty
    a_slope_bound: assert property (p_slope_bound)
        else $error("output phase moved more than one slope step");

endmodule : rsl_slope_limiter

/* rtl/rsl_ref_sel_lock.sv */
// reference selection, hitless switch, lock qualify, slope limit and holdover capture
// How it works
// - select pin low picks first reference, high picks second; controller drives it.
// - select change in normal mode switches reference without output phase hit.
// - switch pushing output outside lock window drops lock, restarts timer, full lock time.
// - switch keeping output inside lock window keeps lock asserted throughout; a switch while the current reference is disrupted drops lock.
// - output phase change is limited to a fixed slope of 61 us/s.
// - holdover frequency is captured only in normal mode while locked.
// - a select change in auto mode normal state goes to holdover then back through tie correction.
// - state pins: 00 auto normal, 01 holdover, 10 freerun, 11 unused.
// - locked normal stores frequency alternately every 26 ms; holdover uses older one.
`timescale 1ns/100ps
module rsl_ref_sel_lock #(
    parameter int HOLD_SLOT_CYC  = rsl_pkg::HOLD_SLOT_CYC,
    parameter int LOCK_CYC       = rsl_pkg::LOCK_CYC,
    parameter int SLOPE_TICK_CYC = rsl_pkg::SLOPE_TICK_CYC
) (
    // clock and reset
    input  wire logic                              ref_clk_i,
    input  wire logic                              rst_i,
    // control pins
    input  wire logic                              ref_sel_i,
    input  wire logic                              operating_state_select_high_i,
    input  wire logic                              operating_state_select_low_i,
    input  wire logic                              holdover_recovery_choice_i,
    // reference monitor and loop inputs
    input  wire logic                              first_reference_disrupted_i,
    input  wire logic                              second_reference_disrupted_i,
    input  wire logic signed [rsl_pkg::PHASE_W-1:0] phase_err_i,
    input  wire logic [rsl_pkg::FREQ_W-1:0]        loop_freq_i,
    // status outputs
    output logic                                   active_ref_o,
    output logic                                   lock_o,
    output logic                                   holdover_o,
    output logic [rsl_pkg::FREQ_W-1:0]             freq_word_o,
    output logic signed [rsl_pkg::PHASE_W-1:0]     phase_adj_o,
    output logic                                   irq_o,
    // apb slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [rsl_pkg::ADDR_W-1:0]        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic [31:0]                            prdata,
    output logic                                   pready,
    output logic                                   pslverr
);
    localparam int PW = rsl_pkg::PHASE_W;
    localparam int FW = rsl_pkg::FREQ_W;
    localparam int IW = rsl_pkg::IRQ_W;
    localparam int LW = $clog2(LOCK_CYC + 1);
    localparam int HW = $clog2(HOLD_SLOT_CYC + 1);

    // state machine and reference selection
    rsl_pkg::rsl_state_t  state_q, state_d;
    logic                 ref_sel_q, ref_sel_d;
    logic                 sw_pend_q, sw_pend_d;
    logic                 lock_q, lock_d;
    logic [LW-1:0]        lock_cnt_q, lock_cnt_d;
    logic signed [PW-1:0] tie_off_q, tie_off_d;
    logic signed [PW-1:0] last_corr_q, last_corr_d;
    logic [FW-1:0]        freq_q, freq_d;
    logic [1:0]           mode;
    logic                 sel_chg, ref_bad, in_win, switching;
    logic signed [PW-1:0] corr_err;
    logic [PW-1:0]        corr_mag;
    logic [IW-1:0]        irq_evt;

    // holdover storage
    logic [FW-1:0]        slot_q [2];
    logic [FW-1:0]        slot_d [2];
    logic                 wr_ptr_q, wr_ptr_d;
    logic [HW-1:0]        slot_cnt_q, slot_cnt_d;
    logic [FW-1:0]        hold_q, hold_d;

    // registers
    logic [IW-1:0]        irq_stat_q, irq_stat_d;
    logic [IW-1:0]        irq_mask_q, irq_mask_d;
    logic [PW-1:0]        lock_win_q, lock_win_d;
    logic [31:0]          prdata_q, prdata_d;
    logic                 wr_en, rd_setup, addr_ok;

    assign mode     = {operating_state_select_high_i, operating_state_select_low_i};
    assign sel_chg  = ref_sel_i != ref_sel_q;
    assign ref_bad  = ref_sel_q ? second_reference_disrupted_i : first_reference_disrupted_i;
    assign corr_err = phase_err_i - tie_off_q;
    assign corr_mag = corr_err[PW-1] ? PW'(-corr_err) : PW'(corr_err);
    assign in_win   = corr_mag <= lock_win_q;
    assign switching = sw_pend_q || (state_q == rsl_pkg::ST_TIE);

    always_comb begin
        state_d     = state_q;
        ref_sel_d   = ref_sel_i;
        sw_pend_d   = sw_pend_q;
        tie_off_d   = tie_off_q;
        last_corr_d = last_corr_q;
        if (sel_chg) begin
            sw_pend_d = 1'b1;
        end
        unique case (mode)
            rsl_pkg::MODE_HOLD: state_d = rsl_pkg::ST_HOLD;
            rsl_pkg::MODE_FREE: state_d = rsl_pkg::ST_FREE;
            rsl_pkg::MODE_AUTO: begin
                unique case (state_q)
                    rsl_pkg::ST_FREE: state_d = rsl_pkg::ST_HOLD;
                    rsl_pkg::ST_NORMAL: begin
                        // on the select edge the error already shows the new reference
                        if (!sel_chg) begin
                            last_corr_d = corr_err;
                        end
                        if (sel_chg || ref_bad) begin
                            state_d = rsl_pkg::ST_HOLD;
                        end
                    end
                    rsl_pkg::ST_HOLD: begin
                        if (!ref_bad && !sel_chg) begin
                            if (sw_pend_q || holdover_recovery_choice_i) begin
                                state_d = rsl_pkg::ST_TIE;
                            end else begin
                                state_d   = rsl_pkg::ST_NORMAL;
                                tie_off_d = '0;
                            end
                        end
                    end
                    rsl_pkg::ST_TIE: begin
                        // keep the corrected error where it was, so the output sees no jump
                        tie_off_d = phase_err_i - last_corr_q;
                        state_d   = rsl_pkg::ST_NORMAL;
                        sw_pend_d = 1'b0;
                    end
                endcase
            end
            default: state_d = state_q;
        endcase
        if (mode != rsl_pkg::MODE_AUTO) begin
            sw_pend_d = 1'b0;
        end
    end

    // lock qualify timer and lock flag
    always_comb begin
        lock_d     = lock_q;
        lock_cnt_d = '0;
        if (state_q == rsl_pkg::ST_NORMAL) begin
            // the uncorrected error on the select edge is not judged
            if (!in_win && !sel_chg) begin
                lock_d     = 1'b0;
                lock_cnt_d = '0;
            end else if (!lock_q && in_win) begin
                lock_cnt_d = lock_cnt_q + LW'(1);
                if (lock_cnt_q == LW'(LOCK_CYC - 1)) begin
                    lock_d     = 1'b1;
                    lock_cnt_d = '0;
                end
            end
        end else if (!(switching || (sel_chg && lock_q))) begin
            lock_d = 1'b0;
        end
        // a switch inside the window leaves lock_d untouched
        if (state_q == rsl_pkg::ST_NORMAL && state_d == rsl_pkg::ST_HOLD && ref_bad) begin
            lock_d = 1'b0;
        end
    end

    // holdover frequency capture into two alternating slots
    always_comb begin
        slot_d     = slot_q;
        wr_ptr_d   = wr_ptr_q;
        slot_cnt_d = '0;
        hold_d     = hold_q;
        if (state_q == rsl_pkg::ST_NORMAL && lock_q) begin
            slot_cnt_d = slot_cnt_q + HW'(1);
            if (slot_cnt_q == HW'(HOLD_SLOT_CYC - 1)) begin
                slot_cnt_d       = '0;
                slot_d[wr_ptr_q] = loop_freq_i;
                wr_ptr_d         = !wr_ptr_q;
            end
        end
        if (state_q != rsl_pkg::ST_HOLD && state_d == rsl_pkg::ST_HOLD) begin
            // the slot about to be overwritten is the older one
            hold_d = slot_q[wr_ptr_q];
        end
        unique case (state_q)
            rsl_pkg::ST_NORMAL, rsl_pkg::ST_TIE: freq_d = loop_freq_i;
            rsl_pkg::ST_HOLD:                    freq_d = hold_q;
            rsl_pkg::ST_FREE:                    freq_d = rsl_pkg::FREQ_NOMINAL;
        endcase
    end

    rsl_slope_limiter #(
        .PW       (PW),
        .STEP     (rsl_pkg::SLOPE_STEP_NS),
        .TICK_CYC (SLOPE_TICK_CYC)
    ) u_slope (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .en_i      (state_q == rsl_pkg::ST_NORMAL && !sel_chg),
        .target_i  (corr_err),
        .phase_o   (phase_adj_o)
    );

    // apb register file and interrupts
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign addr_ok  = paddr == rsl_pkg::REG_STATUS || paddr == rsl_pkg::REG_IRQ_STAT ||
                      paddr == rsl_pkg::REG_IRQ_MASK || paddr == rsl_pkg::REG_LOCK_WIN ||
                      paddr == rsl_pkg::REG_HOLD_FREQ;

    always_comb begin
        irq_evt = '0;
        irq_evt[rsl_pkg::IRQ_LOCK_GAIN]  = lock_d && !lock_q;
        irq_evt[rsl_pkg::IRQ_LOCK_LOSS]  = !lock_d && lock_q;
        irq_evt[rsl_pkg::IRQ_REF_SWITCH] = sel_chg;
        irq_evt[rsl_pkg::IRQ_HOLD_ENTRY] = state_d == rsl_pkg::ST_HOLD &&
                                           state_q != rsl_pkg::ST_HOLD;
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        lock_win_d = lock_win_q;
        prdata_d   = prdata_q;
        if (wr_en && paddr == rsl_pkg::REG_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~pwdata[IW-1:0];
        end
        // a new event wins over a clear in the same cycle
        irq_stat_d = irq_stat_d | irq_evt;
        if (wr_en && paddr == rsl_pkg::REG_IRQ_MASK) begin
            irq_mask_d = pwdata[IW-1:0];
        end
        if (wr_en && paddr == rsl_pkg::REG_LOCK_WIN) begin
            lock_win_d = pwdata[PW-1:0];
        end
        if (rd_setup) begin
            prdata_d = '0;
            unique case (paddr)
                rsl_pkg::REG_STATUS: begin
                    prdata_d[rsl_pkg::ST_LOCK_BIT] = lock_q;
                    prdata_d[rsl_pkg::ST_REF_BIT]  = ref_sel_q;
                    prdata_d[rsl_pkg::ST_STATE_LSB +: 2] = state_q;
                end
                rsl_pkg::REG_IRQ_STAT:  prdata_d[IW-1:0] = irq_stat_q;
                rsl_pkg::REG_IRQ_MASK:  prdata_d[IW-1:0] = irq_mask_q;
                rsl_pkg::REG_LOCK_WIN:  prdata_d[PW-1:0] = lock_win_q;
                rsl_pkg::REG_HOLD_FREQ: prdata_d = hold_q;
                default:                prdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q     <= rsl_pkg::ST_HOLD;
            ref_sel_q   <= 1'b0;
            sw_pend_q   <= 1'b0;
            lock_q      <= 1'b0;
            lock_cnt_q  <= '0;
            tie_off_q   <= '0;
            last_corr_q <= '0;
            freq_q      <= rsl_pkg::FREQ_NOMINAL;
            slot_q[0]   <= rsl_pkg::FREQ_NOMINAL;
            slot_q[1]   <= rsl_pkg::FREQ_NOMINAL;
            wr_ptr_q    <= 1'b0;
            slot_cnt_q  <= '0;
            hold_q      <= rsl_pkg::FREQ_NOMINAL;
            irq_stat_q  <= '0;
            irq_mask_q  <= rsl_pkg::IRQ_MASK_RST;
            lock_win_q  <= rsl_pkg::LOCK_WIN_RST;
            prdata_q    <= '0;
        end else begin
            state_q     <= state_d;
            ref_sel_q   <= ref_sel_d;
            sw_pend_q   <= sw_pend_d;
            lock_q      <= lock_d;
            lock_cnt_q  <= lock_cnt_d;
            tie_off_q   <= tie_off_d;
            last_corr_q <= last_corr_d;
            freq_q      <= freq_d;
            slot_q      <= slot_d;
            wr_ptr_q    <= wr_ptr_d;
            slot_cnt_q  <= slot_cnt_d;
            hold_q      <= hold_d;
            irq_stat_q  <= irq_stat_d;
            irq_mask_q  <= irq_mask_d;
            lock_win_q  <= lock_win_d;
            prdata_q    <= prdata_d;
        end
    end

    assign active_ref_o = ref_sel_q;
    assign lock_o       = lock_q;
    assign holdover_o   = state_q == rsl_pkg::ST_HOLD;
    assign freq_word_o  = freq_q;
    assign irq_o        = |(irq_stat_q & irq_mask_q);
    assign prdata       = prdata_q;
    assign pready       = 1'b1;
    assign pslverr      = psel && penable && !addr_ok;

    // checks
    property p_ref_map;
        @(posedge ref_clk_i) disable iff (rst_i)
        ##1 (active_ref_o == $past(ref_sel_i));
    endproperty
    a_ref_map: assert property (p_ref_map)
        else $error("active reference does not follow the select pin");

    property p_mode_pins;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mode == rsl_pkg::MODE_HOLD) |=> (state_q == rsl_pkg::ST_HOLD);
    endproperty
    a_mode_pins: assert property (p_mode_pins)
        else $error("forced holdover pins did not give holdover");

    sequence s_sw_hold;
        (state_q == rsl_pkg::ST_HOLD) && !ref_bad && !sel_chg &&
        (mode == rsl_pkg::MODE_AUTO);
    endsequence
    property p_switch_path;
        @(posedge ref_clk_i) disable iff (rst_i)
        (state_q == rsl_pkg::ST_NORMAL && sel_chg && mode == rsl_pkg::MODE_AUTO)
        |=> (state_q == rsl_pkg::ST_HOLD) and (s_sw_hold |=> state_q == rsl_pkg::ST_TIE);
    endproperty
    a_switch_path: assert property (p_switch_path)
        else $error("reference change did not pass holdover then tie correction");

    property p_hitless;
        @(posedge ref_clk_i) disable iff (rst_i)
        (state_q == rsl_pkg::ST_TIE && mode == rsl_pkg::MODE_AUTO)
        |=> (phase_err_i - tie_off_q == phase_err_i - $past(phase_err_i) + $past(last_corr_q));
    endproperty
    a_hitless: assert property (p_hitless)
        else $error("tie correction did not preserve the corrected phase");

    property p_drop_lock;
        @(posedge ref_clk_i) disable iff (rst_i)
        (lock_q && state_q == rsl_pkg::ST_NORMAL && !in_win && !sel_chg)
        |=> (!lock_o && lock_cnt_q == '0);
    endproperty
    a_drop_lock: assert property (p_drop_lock)
        else $error("lock not dropped with the timer restarted");

    property p_keep_lock;
        @(posedge ref_clk_i) disable iff (rst_i)
        (lock_q && sel_chg && state_q == rsl_pkg::ST_NORMAL && !ref_bad &&
         mode == rsl_pkg::MODE_AUTO) |=> lock_o;
    endproperty
    a_keep_lock: assert property (p_keep_lock)
        else $error("lock fell on a reference switch");

    property p_qualify;
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(lock_q) |-> ($past(lock_cnt_q) == LW'(LOCK_CYC - 1)) && $past(in_win);
    endproperty
    a_qualify: assert property (p_qualify)
        else $error("lock rose before the full qualify time");

    property p_capture_gate;
        @(posedge ref_clk_i) disable iff (rst_i)
        !(state_q == rsl_pkg::ST_NORMAL && lock_q) |=> ($stable(slot_q[0]) && $stable(slot_q[1]));
    endproperty
    a_capture_gate: assert property (p_capture_gate)
        else $error("holdover slot written outside locked normal");

    property p_hold_apply;
        @(posedge ref_clk_i) disable iff (rst_i)
        (state_q == rsl_pkg::ST_NORMAL && state_d == rsl_pkg::ST_HOLD)
        |=> (hold_q == $past(slot_q[wr_ptr_q])) ##1 (freq_word_o == hold_q);
    endproperty
    a_hold_apply: assert property (p_hold_apply)
        else $error("holdover did not apply the older stored value");

endmodule : rsl_ref_sel_lock

/* verification/rsl_ref_model.sv */
// line references and their disruption flags as the device sees them
`timescale 1ns/100ps
module rsl_ref_model (
    // controller side
    input  wire logic               sel_i,
    input  wire logic signed [15:0] ofs0_i,
    input  wire logic signed [15:0] ofs1_i,
    input  wire logic               bad0_i,
    input  wire logic               bad1_i,
    // device side
    output logic signed [15:0]      perr_o,
    output logic                    dis0_o,
    output logic                    dis1_o
);
    // only the chosen reference reaches the phase detector
    assign perr_o = sel_i ? ofs1_i : ofs0_i;
    assign dis0_o = bad0_i;
    assign dis1_o = bad1_i;
endmodule : rsl_ref_model

/* verification/rsl_ref_sel_lock_bench.sv */
// self-checking bench for reference select and lock indication
`timescale 1ns/100ps
module rsl_ref_sel_lock_bench;
    localparam int LOCK = 20;
    localparam logic [31:0] FA = 32'h0000_A5A5;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;} rsl_row_t;
    logic               ref_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0;
    logic               sel = 1'b0, mh = 1'b0, ml = 1'b0, holdover_recovery_choice = 1'b1, bad0 = 1'b1;
    logic               bad1 = 1'b0, pwrite = 1'b0, seen;
    logic [7:0]         paddr = '0;
    logic [31:0]        pwdata = '0, lfreq = FA, prdata, fword, rd;
    logic signed [15:0] ofs0 = '0, ofs1 = '0, perr, padj, padj_q;
    logic               pready, pslverr, err, aref, lock, hold, irq, dis0, dis1;
    int                 miscompares = 0, cmp_count = 0, slope_bad = 0, c;
    rsl_row_t           rows [7];

    rsl_ref_model i_rsl_ref_model (.sel_i(sel), .ofs0_i(ofs0), .ofs1_i(ofs1), .bad0_i(bad0),
        .bad1_i(bad1), .perr_o(perr), .dis0_o(dis0), .dis1_o(dis1));
    rsl_ref_sel_lock #(.HOLD_SLOT_CYC(16), .LOCK_CYC(LOCK), .SLOPE_TICK_CYC(4)) i_rsl_ref_sel_lock (
        .ref_clk_i, .rst_i, .ref_sel_i(sel), .operating_state_select_high_i(mh),
        .operating_state_select_low_i(ml), .holdover_recovery_choice_i(holdover_recovery_choice),
        .first_reference_disrupted_i(dis0), .second_reference_disrupted_i(dis1),
        .phase_err_i(perr), .loop_freq_i(lfreq), .active_ref_o(aref), .lock_o(lock),
        .holdover_o(hold), .freq_word_o(fword), .phase_adj_o(padj), .irq_o(irq),
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

    always #20 ref_clk_i = ~ref_clk_i;

    // output phase may move by one slope step per cycle at most
    always @(posedge ref_clk_i) begin
        padj_q <= padj;
        if (!rst_i && (padj - padj_q > 61 || padj_q - padj > 61)) slope_bad <= slope_bad + 1;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick

    task automatic wait_lock(input logic v);
        for (c = 0; c < 300; c++) begin
            if (lock === v) return;
            tick(1);
        end
        miscompares++;
        summarize();
    endtask : wait_lock

    // one transfer; the request stands until pready is seen high, and the run ends as failed after 8 cycles without it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        tick(1);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        for (k = 0; k < 8; k++) begin
            tick(1);
            if (pready === 1'b1) break;
        end
        if (k == 8) begin
            miscompares++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    initial begin
        rows = '{'{rsl_pkg::REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
                 '{rsl_pkg::REG_LOCK_WIN, 32'h1234_5678, 32'h0000_5678, 1'b0},
                 '{rsl_pkg::REG_LOCK_WIN, 32'h0000_0064, 32'h0000_0064, 1'b0},
                 '{rsl_pkg::REG_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_000F, 1'b0},
                 '{rsl_pkg::REG_IRQ_MASK, 32'h0000_0000, 32'h0000_0000, 1'b0},
                 '{rsl_pkg::REG_HOLD_FREQ, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
                 '{8'h14, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
        tick(20);
        rst_i <= 1'b0;
        tick(2);
        chk(32'(hold), 32'h1);
        chk(32'(lock), 32'h0);
        chk(fword, 32'h0);
        chk(32'(aref), 32'h0);
        chk(32'(irq), 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            chk(32'(err), 32'(rows[i].x));
            apb(1'b0, rows[i].a, 32'h0000_0000);
            chk(rd, rows[i].e);
            chk(32'(err), 32'(rows[i].x));
        end
        $display("reset and registers done");
        bad0 <= 1'b0;
        wait_lock(1'b1);
        chk(32'(c >= LOCK), 32'h1);
        $display("lock acquisition done");
        tick(40);
        lfreq <= 32'h0000_5A5A;
        tick(10);
        // controller applies only the three defined state codes
        ml <= 1'b1;
        tick(3);
        chk(32'(hold), 32'h1);
        chk(fword, FA);
        lfreq <= 32'h0000_3C3C;
        tick(40);
        chk(fword, FA);
        ml <= 1'b0;
        mh <= 1'b1;
        tick(3);
        chk(32'(hold), 32'h0);
        chk(fword, 32'h0);
        mh <= 1'b0;
        holdover_recovery_choice <= 1'b0;
        wait_lock(1'b1);
        $display("holdover capture done");
        apb(1'b1, rsl_pkg::REG_IRQ_STAT, 32'h0000_000F);
        ofs1 <= 16'h0400;
        sel  <= 1'b1;
        seen = 1'b0;
        repeat (8) begin
            tick(1);
            chk(32'(lock), 32'h1);
            chk(32'(padj), 32'h0);
            seen = seen | hold;
        end
        chk(32'(seen), 32'h1);
        chk(32'(aref), 32'h1);
        chk(32'(irq), 32'h0);
        apb(1'b0, rsl_pkg::REG_IRQ_STAT, 32'h0000_0000);
        chk(32'(rd[2]), 32'h1);
        apb(1'b1, rsl_pkg::REG_IRQ_MASK, 32'h0000_0004);
        tick(2);
        chk(32'(irq), 32'h1);
        apb(1'b1, rsl_pkg::REG_IRQ_STAT, 32'h0000_0004);
        tick(2);
        chk(32'(irq), 32'h0);
        $display("hitless switch and interrupt done");
        sel <= 1'b0;
        tick(6);
        // new reference drifts far outside the window
        ofs0 <= 16'h01F4;
        wait_lock(1'b0);
        tick(3);
        ofs0 <= 16'h0000;
        wait_lock(1'b1);
        chk(32'(c >= LOCK - 1), 32'h1);
        chk(32'(slope_bad), 32'h0);
        $display("lock drop and slope done");
        summarize();
    end
endmodule : rsl_ref_sel_lock_bench
